/* File: logic/btg_cfg.svh */
// Purpose: named constants of the buzzer tone generator
// Assumes: low-speed oscillator nominal 32768 Hz, 256 Hz sync tick
// Notes:   times are in microseconds; tick counts derive from them
`ifndef BTG_CFG_SVH
`define BTG_CFG_SVH

// oscillator periods per 256 Hz tick (32768 / 256)
`define BTG_OSC_PER_TICK   128
`define BTG_TICK_HZ        256
`define BTG_US_PER_S       1000000
// envelope step and burst length times
`define BTG_ENV_FAST_US    62500
`define BTG_ENV_SLOW_US    125000
`define BTG_BURST_SHORT_US 31250
`define BTG_BURST_LONG_US  125000
// time in microseconds to whole 256 Hz ticks
`define BTG_TICKS(us)      (((us) * `BTG_TICK_HZ) / `BTG_US_PER_S)
// tone period and high-time shape
`define BTG_PERIOD_MIN     5'h10
`define BTG_PERIOD_STEP    5'h04
`define BTG_HIGH_SHORT     5'h08
`define BTG_HIGH_LONG      5'h0C
// duty levels
`define BTG_LEVEL_MAX      3'h7
`define BTG_LEVEL_MIN      3'h0
// envelope and burst tick counter width
`define BTG_CNT_W          6

`endif

/* File: logic/btg_pkg.sv */
// Purpose: shared types of the buzzer tone generator
// Assumes: nothing beyond the constants header
// Notes:   select codes are three bits wide
package btg_pkg;
    typedef logic [2:0] btg_sel_t;
    typedef enum logic [1:0] {
        BTG_B_IDLE,
        BTG_B_ARM,
        BTG_B_RUN,
        BTG_B_HALT
    } btg_burst_st_t;
endpackage : btg_pkg

/* File: logic/btg_tone_if.sv */
// Purpose: link between burst/envelope control and the waveform stage
// Assumes: one clock domain
// Notes:   unit_tick is a one-cycle pulse per duty unit
`timescale 1ns/10ps
interface btg_tone_if;
    logic              unit_tick;
    btg_pkg::btg_sel_t freq;
    btg_pkg::btg_sel_t level;
    logic              wave;
    modport gen  (input unit_tick, input freq, input level, output wave);
    modport user (output unit_tick, output freq, output level, input wave);
endinterface : btg_tone_if

/* File: logic/btg_wave.sv */
// Purpose: tone waveform from unit ticks, frequency and duty level
// Assumes: unit_tick pulses at 65536 or 32768 Hz nominal
// Notes:   wave is high for the high time at the start of each period
`timescale 1ns/10ps
`include "btg_cfg.svh"
module btg_wave (
    input  wire logic core_clk_in,
    input  wire logic rstn_in,
    btg_tone_if.gen   tone_if
);
    import btg_pkg::*;

    logic [4:0] cnt_ff;
    logic [4:0] nxt_cnt;
    logic       wave_ff;
    logic       nxt_wave;
    logic [4:0] period;
    logic [4:0] high_units;

    // period 16/20/24/28 units, high time base 8 or 12 minus level
    always_comb begin
        period     = `BTG_PERIOD_MIN
                   + `BTG_PERIOD_STEP * {3'h0, tone_if.freq[1:0]};
        high_units = (tone_if.freq[1] ? `BTG_HIGH_LONG : `BTG_HIGH_SHORT)
                   - {2'h0, tone_if.level};
    end

    // unit counter and positive-polarity compare
    always_comb begin
        nxt_cnt = cnt_ff;
        if (tone_if.unit_tick) begin
            if (cnt_ff >= period - 5'h01) begin
                nxt_cnt = 5'h00;
            end else begin
                nxt_cnt = cnt_ff + 5'h01;
            end
        end
        nxt_wave = (nxt_cnt < high_units);
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            cnt_ff  <= 5'h00;
            wave_ff <= 1'b1; // period starts high, matches count zero
        end else begin
            cnt_ff  <= nxt_cnt;
            wave_ff <= nxt_wave;
        end
    end

    assign tone_if.wave = wave_ff;

    a_period_wrap: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (tone_if.unit_tick && cnt_ff == period - 5'h01
         && $stable(tone_if.freq)) |=> (cnt_ff == 5'h00)
    ) else $error("unit counter did not wrap at period end");

    a_period_start_high: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (cnt_ff == 5'h00) |-> wave_ff
    ) else $error("tone not high at start of period");
endmodule : btg_wave

/* File: logic/btg_top.sv */
// Purpose: buzzer tone generator with envelope and one-shot burst
// Assumes: all inputs synchronous to core_clk_in; oscillator sampled
// Notes:   trigger inputs are one-cycle write strobes
`timescale 1ns/10ps
`include "btg_cfg.svh"
// Overview of operation
// - tone divides low-speed oscillator; eight frequencies 4096.0 to 1170.3 Hz
// - every frequency and time follows oscillator division and scales with it
// - three-bit duty select picks eight levels; each step drops one unit
// - 4096/2048 Hz use 16-unit period, 3276.8/1638.4 Hz use 20 units
// - 2730.7/1365.3 Hz use 24 units, 2340.6/1170.3 Hz use 28 units
// - duty is high time over period for positive polarity
// - after reset pins are port bits; selects route true and inverted tone
// - enable on gives tone; off holds true pin high, inverted low
// - enable switching may glitch the tone at switch on and off
// - envelope start at level 1 as enable turns on, steps down to level 8, then holds
// - while envelope runs the duty select setting is ignored
// - envelope restart returns duty to level 1 and stepping resumes
// - step time 62.5 ms or 125 ms; first step may be 4 ms off
// - burst lasts 31.25 ms or 125 ms by width select
// - burst trigger starts and ends tone on the 256 Hz tick
// - burst status reads 1 while busy, 0 when ready
// - burst stop ends the burst early on the 256 Hz tick
// - trigger during burst restarts full duration on the tick
// - bursts never use envelope; they use selected frequency and duty
// - burst trigger has no effect while continuous enable is 1
// - write-only triggers and unused bits read back as 0
module btg_top #(
    parameter int OSC_PER_TICK = `BTG_OSC_PER_TICK
) (
    input  wire logic              core_clk_in,
    input  wire logic              rstn_in,
    input  wire logic              low_speed_osc_in,
    input  wire logic              buzzer_enable_in,
    input  wire btg_pkg::btg_sel_t tone_freq_select_in,
    input  wire btg_pkg::btg_sel_t tone_duty_select_in,
    input  wire logic              envelope_enable_in,
    input  wire logic              envelope_restart_in,
    input  wire logic              envelope_step_time_in,
    input  wire logic              burst_width_select_in,
    input  wire logic              burst_trigger_in,
    input  wire logic              burst_stop_in,
    input  wire logic              tone_pin_select_in,
    input  wire logic              inverted_tone_pin_select_in,
    input  wire logic              port_bit_one_in,
    input  wire logic              port_bit_zero_in,
    input  wire logic              port_bit_one_float_in,
    input  wire logic              port_bit_zero_float_in,
    output logic                   tone_out_out,
    output logic                   tone_out_oe_out,
    output logic                   tone_out_inverted_out,
    output logic                   tone_out_inverted_oe_out,
    output logic                   burst_busy_out,
    output logic [1:0]             trigger_readback_out
);
    import btg_pkg::*;

    localparam int PW = $clog2(OSC_PER_TICK);
    localparam logic [`BTG_CNT_W-1:0] ENV_FAST =
        `BTG_CNT_W'(`BTG_TICKS(`BTG_ENV_FAST_US));
    localparam logic [`BTG_CNT_W-1:0] ENV_SLOW =
        `BTG_CNT_W'(`BTG_TICKS(`BTG_ENV_SLOW_US));
    localparam logic [`BTG_CNT_W-1:0] BURST_SHORT =
        `BTG_CNT_W'(`BTG_TICKS(`BTG_BURST_SHORT_US));
    localparam logic [`BTG_CNT_W-1:0] BURST_LONG =
        `BTG_CNT_W'(`BTG_TICKS(`BTG_BURST_LONG_US));

    // refuse a prescaler the tick logic cannot serve
    if (OSC_PER_TICK < 2 || OSC_PER_TICK > 4096) begin : g_bad_div
        $error("OSC_PER_TICK out of range");
    end

    btg_tone_if tone_if ();

    btg_wave u_wave (
        .core_clk_in (core_clk_in),
        .rstn_in     (rstn_in),
        .tone_if     (tone_if)
    );

    // ---- oscillator edge detect and 256 Hz prescaler
    logic          osc_ff;
    logic          nxt_osc;
    logic [PW-1:0] pre_ff;
    logic [PW-1:0] nxt_pre;
    logic          osc_rise;
    logic          tick256;

    // both edges give 65536 Hz units, rising edges 32768 Hz units
    always_comb begin
        nxt_osc  = low_speed_osc_in;
        osc_rise = low_speed_osc_in & ~osc_ff;
        tick256  = osc_rise && (pre_ff == PW'(OSC_PER_TICK - 1));
        nxt_pre  = pre_ff;
        if (osc_rise) begin
            nxt_pre = tick256 ? '0 : pre_ff + PW'(1);
        end
        tone_if.unit_tick = tone_freq_select_in[2] ? osc_rise
                          : (low_speed_osc_in ^ osc_ff);
        tone_if.freq      = tone_freq_select_in;
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            osc_ff <= 1'b0;
            pre_ff <= '0;
        end else begin
            osc_ff <= nxt_osc;
            pre_ff <= nxt_pre;
        end
    end

    // ---- digital envelope
    logic                  en_prev_ff;
    logic                  nxt_en_prev;
    btg_sel_t              env_lvl_ff;
    btg_sel_t              nxt_env_lvl;
    logic [`BTG_CNT_W-1:0] env_cnt_ff;
    logic [`BTG_CNT_W-1:0] nxt_env_cnt;
    logic                  env_active;
    logic                  env_start;
    logic [`BTG_CNT_W-1:0] env_step;

    // start/restart to level 1, step each period, hold at level 8
    always_comb begin
        env_active  = buzzer_enable_in & envelope_enable_in;
        env_start   = env_active & ~en_prev_ff;
        env_step    = envelope_step_time_in ? ENV_SLOW : ENV_FAST;
        nxt_en_prev = buzzer_enable_in;
        nxt_env_lvl = env_lvl_ff;
        nxt_env_cnt = env_cnt_ff;
        if (env_start || (env_active && envelope_restart_in)) begin
            nxt_env_lvl = `BTG_LEVEL_MIN;
            nxt_env_cnt = '0;
        end else if (env_active && tick256) begin
            if (env_cnt_ff >= env_step - `BTG_CNT_W'(1)) begin
                nxt_env_cnt = '0;
                if (env_lvl_ff != `BTG_LEVEL_MAX) begin
                    nxt_env_lvl = env_lvl_ff + 3'h1;
                end
            end else begin
                nxt_env_cnt = env_cnt_ff + `BTG_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            en_prev_ff <= 1'b0;
            env_lvl_ff <= `BTG_LEVEL_MIN;
            env_cnt_ff <= '0;
        end else begin
            en_prev_ff <= nxt_en_prev;
            env_lvl_ff <= nxt_env_lvl;
            env_cnt_ff <= nxt_env_cnt;
        end
    end

    // ---- one-shot burst
    btg_burst_st_t         bst_ff;
    btg_burst_st_t         nxt_bst;
    logic [`BTG_CNT_W-1:0] bcnt_ff;
    logic [`BTG_CNT_W-1:0] nxt_bcnt;
    logic                  snd_ff;
    logic                  nxt_snd;
    logic [`BTG_CNT_W-1:0] burst_len;
    logic                  trig_ok;

    // trigger arms, sound switches only on the 256 Hz tick
    always_comb begin
        burst_len = burst_width_select_in ? BURST_LONG : BURST_SHORT;
        trig_ok   = burst_trigger_in & ~buzzer_enable_in;
        nxt_bst   = bst_ff;
        nxt_bcnt  = bcnt_ff;
        nxt_snd   = snd_ff;
        if (trig_ok) begin
            nxt_bst = BTG_B_ARM;
        end else if (burst_stop_in && bst_ff != BTG_B_IDLE) begin
            nxt_bst = BTG_B_HALT;
        end else if (tick256) begin
            case (bst_ff)
                BTG_B_ARM: begin
                    nxt_bst  = BTG_B_RUN;
                    nxt_bcnt = burst_len;
                    nxt_snd  = 1'b1;
                end
                BTG_B_RUN: begin
                    if (bcnt_ff <= `BTG_CNT_W'(1)) begin
                        nxt_bst = BTG_B_IDLE;
                        nxt_snd = 1'b0;
                    end else begin
                        nxt_bcnt = bcnt_ff - `BTG_CNT_W'(1);
                    end
                end
                BTG_B_HALT: begin
                    nxt_bst = BTG_B_IDLE;
                    nxt_snd = 1'b0;
                end
                default: begin
                    nxt_bst = BTG_B_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            bst_ff  <= BTG_B_IDLE;
            bcnt_ff <= '0;
            snd_ff  <= 1'b0;
        end else begin
            bst_ff  <= nxt_bst;
            bcnt_ff <= nxt_bcnt;
            snd_ff  <= nxt_snd;
        end
    end

    // ---- duty source and pin multiplexing
    logic run;
    logic true_lvl;
    logic inv_lvl;
    logic tone_ff;
    logic nxt_tone;
    logic tinv_ff;
    logic nxt_tinv;
    logic toe_ff;
    logic nxt_toe;
    logic ioe_ff;
    logic nxt_ioe;

    // continuous enable gates tone directly, glitches tolerated
    always_comb begin
        tone_if.level = env_active ? env_lvl_ff
                      : tone_duty_select_in;
        run      = buzzer_enable_in | snd_ff;
        true_lvl = run ? tone_if.wave : 1'b1;
        inv_lvl  = run ? ~tone_if.wave : 1'b0;
        nxt_tone = tone_pin_select_in ? true_lvl : port_bit_one_in;
        nxt_tinv = inverted_tone_pin_select_in ? inv_lvl
                 : port_bit_zero_in;
        nxt_toe  = ~port_bit_one_float_in;
        nxt_ioe  = ~port_bit_zero_float_in;
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            tone_ff <= 1'b1;
            tinv_ff <= 1'b1;
            toe_ff  <= 1'b1;
            ioe_ff  <= 1'b1;
        end else begin
            tone_ff <= nxt_tone;
            tinv_ff <= nxt_tinv;
            toe_ff  <= nxt_toe;
            ioe_ff  <= nxt_ioe;
        end
    end

    assign tone_out_out             = tone_ff;
    assign tone_out_inverted_out    = tinv_ff;
    assign tone_out_oe_out          = toe_ff;
    assign tone_out_inverted_oe_out = ioe_ff;
    assign burst_busy_out           = (bst_ff != BTG_B_IDLE);
    assign trigger_readback_out     = 2'h0;

    // ---- checks
    a_disabled_high: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (tone_pin_select_in && inverted_tone_pin_select_in
         && !buzzer_enable_in && !snd_ff)
        |=> (tone_out_out && !tone_out_inverted_out)
    ) else $error("idle pins not high and low");

    a_pins_complement: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (tone_pin_select_in && inverted_tone_pin_select_in && run)
        |=> (tone_out_out != tone_out_inverted_out)
    ) else $error("inverted pin not complement of true pin");

    a_port_passthru: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        !tone_pin_select_in |=> (tone_out_out == $past(port_bit_one_in))
    ) else $error("port bit not passed to pin");

    a_burst_busy_set: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        trig_ok |=> burst_busy_out [*2]
    ) else $error("busy not shown after trigger");

    a_burst_ignored: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (buzzer_enable_in && burst_trigger_in && bst_ff == BTG_B_IDLE)
        |=> (bst_ff == BTG_B_IDLE)
    ) else $error("trigger accepted while enable set");

    a_sound_on_tick: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (snd_ff != $past(snd_ff)) |-> $past(tick256)
    ) else $error("burst sound changed off the tick");

    a_burst_load: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (bst_ff == BTG_B_ARM && tick256 && !burst_trigger_in
         && !burst_stop_in) |=> (bcnt_ff == $past(burst_len) && snd_ff)
    ) else $error("burst length not loaded");

    a_stop_on_tick: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (bst_ff == BTG_B_HALT && tick256 && !trig_ok) |=> !snd_ff
    ) else $error("stopped burst still sounding");

    a_env_restart: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (env_active && envelope_restart_in)
        |=> (env_lvl_ff == `BTG_LEVEL_MIN && env_cnt_ff == '0)
    ) else $error("envelope restart did not reach level 1");

    a_env_hold: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (env_lvl_ff == `BTG_LEVEL_MAX && !env_start
         && !envelope_restart_in) |=> (env_lvl_ff == `BTG_LEVEL_MAX)
    ) else $error("envelope left level 8");
endmodule : btg_top

/* File: verif/btg_buzzer_model.sv */
// Purpose: piezo buzzer model that measures the tone on the true pin
// Assumes: pin sampled on core_clk_in; positive polarity, high first
// Notes:   a rise is reported only if an earlier rise was seen recently
`timescale 1ns/10ps
module btg_buzzer_model (
    input  wire logic        core_clk_in,
    input  wire logic        pin_level_in,
    output logic             pulse_stb_out,
    output logic [11:0]      high_cnt_out,
    output logic [11:0]      per_cnt_out
);
    logic        last_ff = 1'b1;
    logic        seen_ff = 1'b0;
    logic [11:0] per_ff  = 12'h000;
    logic [11:0] high_ff = 12'h000;
    logic [11:0] idle_ff = 12'h000;

    // a rise closes one period; a long quiet pin forgets the last rise
    always @(posedge core_clk_in) begin
        last_ff       <= pin_level_in;
        pulse_stb_out <= 1'b0;
        idle_ff <= (pin_level_in != last_ff) ? 12'h000 : idle_ff + 12'h001;
        if (pin_level_in && !last_ff) begin
            pulse_stb_out <= seen_ff;
            high_cnt_out  <= high_ff;
            per_cnt_out   <= per_ff;
            per_ff        <= 12'h001;
            high_ff       <= 12'h001;
            seen_ff       <= 1'b1;
        end else begin
            per_ff  <= per_ff + 12'h001;
            high_ff <= high_ff + {11'h000, pin_level_in};
            if (idle_ff > 12'h1F4) seen_ff <= 1'b0; // longer than any period
        end
    end
endmodule : btg_buzzer_model

/* File: verif/tb_top.sv */
// Purpose: self-checking bench of the buzzer tone generator
// Assumes: oscillator sped up, tick shortened through OSC_PER_TICK
// Notes:   pulse notes are queued; the monitor takes one per pulse
`timescale 1ns/10ps
module tb_top;
    import btg_pkg::*;
    localparam int H  = 8;          // core cycles per osc half period
    localparam int PT = 4;          // osc periods per tick
    localparam int TK = PT * 2 * H; // core cycles per tick
    typedef struct { int hi; int per; } btg_exp_t;
    logic        core_clk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic        low_speed_osc_in = 1'b0;
    logic        buzzer_enable_in = 1'b0;
    btg_sel_t    tone_freq_select_in = 3'h0;
    btg_sel_t    tone_duty_select_in = 3'h0;
    logic        envelope_enable_in = 1'b0;
    logic        envelope_restart_in = 1'b0;
    logic        envelope_step_time_in = 1'b0;
    logic        burst_width_select_in = 1'b0;
    logic        burst_trigger_in = 1'b0;
    logic        burst_stop_in = 1'b0;
    logic        tone_pin_select_in = 1'b0;
    logic        inverted_tone_pin_select_in = 1'b0;
    logic        port_bit_one_in = 1'b1;
    logic        port_bit_zero_in = 1'b1;
    logic        port_bit_one_float_in = 1'b0;
    logic        port_bit_zero_float_in = 1'b0;
    logic        tone_out_out, tone_out_oe_out;
    logic        tone_out_inverted_out, tone_out_inverted_oe_out;
    logic        burst_busy_out, pulse_stb, sel_d = 1'b0;
    logic [1:0]  trigger_readback_out;
    logic [11:0] high_cnt, per_cnt;
    btg_exp_t    exp_q[$];
    int          miscompares = 0, checks_done = 0, cyc_cnt = 0;
    int          seed = 33, t0 = 0, n = 0;

    btg_top #(.OSC_PER_TICK(PT)) uut (
        .core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .low_speed_osc_in(low_speed_osc_in),
        .buzzer_enable_in(buzzer_enable_in),
        .tone_freq_select_in(tone_freq_select_in),
        .tone_duty_select_in(tone_duty_select_in),
        .envelope_enable_in(envelope_enable_in),
        .envelope_restart_in(envelope_restart_in),
        .envelope_step_time_in(envelope_step_time_in),
        .burst_width_select_in(burst_width_select_in),
        .burst_trigger_in(burst_trigger_in), .burst_stop_in(burst_stop_in),
        .tone_pin_select_in(tone_pin_select_in),
        .inverted_tone_pin_select_in(inverted_tone_pin_select_in),
        .port_bit_one_in(port_bit_one_in), .port_bit_zero_in(port_bit_zero_in),
        .port_bit_one_float_in(port_bit_one_float_in),
        .port_bit_zero_float_in(port_bit_zero_float_in),
        .tone_out_out(tone_out_out), .tone_out_oe_out(tone_out_oe_out),
        .tone_out_inverted_out(tone_out_inverted_out),
        .tone_out_inverted_oe_out(tone_out_inverted_oe_out),
        .burst_busy_out(burst_busy_out),
        .trigger_readback_out(trigger_readback_out));

    btg_buzzer_model buzzer (.core_clk_in(core_clk_in),
        .pin_level_in(tone_out_out), .pulse_stb_out(pulse_stb),
        .high_cnt_out(high_cnt), .per_cnt_out(per_cnt));

    // clock, sped-up oscillator and a cycle count
    always #4 core_clk_in = ~core_clk_in;
    always begin
        repeat (H) @(posedge core_clk_in);
        #1 low_speed_osc_in = ~low_speed_osc_in;
    end
    always @(posedge core_clk_in) cyc_cnt <= cyc_cnt + 1;

    // watch the pin pair and take one note per measured pulse
    always @(posedge core_clk_in) begin
        sel_d <= tone_pin_select_in & inverted_tone_pin_select_in;
        if (rstn_in === 1'b1 && sel_d === 1'b1)
            check_bit(tone_out_inverted_out, ~tone_out_out, "inverse");
        if (pulse_stb === 1'b1 && exp_q.size() > 0)
            check_pulse(high_cnt, per_cnt, exp_q.pop_front());
    end

    task automatic cyc(input int c);
        repeat (c) @(posedge core_clk_in);
        #1;
    endtask : cyc

    task automatic check_bit(input logic got, input logic ex, input string m);
        checks_done++;
        if (got !== ex) begin
            miscompares++;
            $display("[ERR] %0t %s got %b exp %b", $time, m, got, ex);
        end
    endtask : check_bit

    task automatic check_range(input int v, input int lo, input int hi);
        checks_done++;
        if (v < lo || v > hi) begin
            miscompares++;
            $display("[ERR] %0t length %0d outside %0d..%0d", $time, v, lo, hi);
        end
    endtask : check_range

    task automatic check_pulse(input logic [11:0] hi, input logic [11:0] per,
                               input btg_exp_t e);
        checks_done++;
        if (hi !== e.hi[11:0] || per !== e.per[11:0]) begin
            miscompares++;
            $display("[ERR] %0t pulse %0d/%0d exp %0d/%0d", $time, hi, per,
                     e.hi, e.per);
        end
    endtask : check_pulse

    // note one pulse shape and wait until the monitor has taken it
    task automatic expect_pulse(input btg_sel_t f, input btg_sel_t d);
        btg_exp_t e;
        int uc;
        int i;
        uc = f[2] ? 2 * H : H;
        e.hi = ((f[1] ? 12 : 8) - int'(d)) * uc;
        e.per = (16 + 4 * int'(f[1:0])) * uc;
        exp_q.push_back(e);
        for (i = 0; i < 2000 && exp_q.size() > 0; i++) cyc(1);
        if (exp_q.size() > 0) begin
            $display("[ERR] %0t no pulse measured in time", $time);
            miscompares++;
            stop_test();
        end
    endtask : expect_pulse

    // one-cycle strobe: 0 trigger, 1 stop, 2 envelope restart
    task automatic fire(input int w);
        burst_trigger_in = (w == 0);
        burst_stop_in = (w == 1);
        envelope_restart_in = (w == 2);
        t0 = cyc_cnt;
        cyc(1);
        burst_trigger_in = 1'b0;
        burst_stop_in = 1'b0;
        envelope_restart_in = 1'b0;
    endtask : fire

    task automatic wait_idle(output int v);
        int i;
        for (i = 0; i < 5000 && burst_busy_out !== 1'b0; i++) cyc(1);
        if (burst_busy_out !== 1'b0) begin
            $display("[ERR] %0t burst did not end in time", $time);
            miscompares++;
            stop_test();
        end
        v = cyc_cnt - t0;
    endtask : wait_idle

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    // main sequence
    initial begin
        cyc(4);
        rstn_in = 1'b1;
        port_bit_one_in = 1'b0;
        port_bit_zero_in = 1'b0;
        port_bit_zero_float_in = 1'b1;
        cyc(2);
        check_bit(tone_out_out, 1'b0, "port one");
        check_bit(tone_out_inverted_out, 1'b0, "port zero");
        check_bit(tone_out_inverted_oe_out, 1'b0, "float");
        check_bit(tone_out_oe_out, 1'b1, "drive");
        port_bit_one_in = 1'b1;
        port_bit_zero_in = 1'b1;
        port_bit_zero_float_in = 1'b0;
        tone_pin_select_in = 1'b1;
        inverted_tone_pin_select_in = 1'b1;
        cyc(2);
        check_bit(tone_out_out, 1'b1, "off true");
        check_bit(tone_out_inverted_out, 1'b0, "off inv");
        $display("test pins done");
        buzzer_enable_in = 1'b1;
        for (int i = 0; i < 12; i++) begin
            tone_freq_select_in = (i < 8) ? i[2:0] : btg_sel_t'($random(seed));
            tone_duty_select_in = (i < 8) ? 3'h7 - i[2:0]
                                          : btg_sel_t'($random(seed));
            cyc(480); // let switching hazards pass
            expect_pulse(tone_freq_select_in, tone_duty_select_in);
        end
        $display("test tone done");
        buzzer_enable_in = 1'b0;
        tone_freq_select_in = 3'h0;
        tone_duty_select_in = 3'h7;
        envelope_enable_in = 1'b1;
        cyc(2);
        buzzer_enable_in = 1'b1;
        cyc(256);
        expect_pulse(3'h0, 3'h0);
        cyc(8 * 16 * TK);
        expect_pulse(3'h0, 3'h7);
        fire(2);
        cyc(300);
        expect_pulse(3'h0, 3'h0);
        cyc(1000);
        expect_pulse(3'h0, 3'h1);
        envelope_step_time_in = 1'b1;
        fire(2);
        cyc(1400);
        expect_pulse(3'h0, 3'h0);
        buzzer_enable_in = 1'b0;
        $display("test envelope done");
        cyc(600);
        tone_freq_select_in = 3'h5;
        tone_duty_select_in = 3'h2;
        burst_width_select_in = 1'b1;
        fire(0);
        check_bit(burst_busy_out, 1'b1, "busy");
        expect_pulse(3'h5, 3'h2);
        wait_idle(n);
        check_range(n, 32 * TK, 33 * TK + 2);
        check_bit(burst_busy_out, 1'b0, "ready");
        burst_width_select_in = 1'b0;
        cyc(4);
        fire(0);
        wait_idle(n);
        check_range(n, 8 * TK, 9 * TK + 2);
        fire(0);
        cyc(200);
        fire(0);
        wait_idle(n);
        check_range(n, 8 * TK, 9 * TK + 2);
        fire(0);
        cyc(100);
        fire(1);
        wait_idle(n);
        check_range(n, 1, TK + 2);
        buzzer_enable_in = 1'b1;
        fire(0);
        check_bit(burst_busy_out, 1'b0, "refused");
        check_bit(|trigger_readback_out, 1'b0, "readback");
        $display("test burst done");
        stop_test();
    end
endmodule : tb_top
